// File: rtl/close_onto_fault_guard.v
// How it works
// - arm only on rising edge of arm input
// - window lasts release time, default one second
// - start input in window trips at once
// - inhibit input stops the window from starting
// - only binary inputs, no analog measurement
// - force status when global forcing enabled
// - condition shows normal, init, active, trip, blocked
// - on/off events, selectable per event
// - every event carries its time stamp
// - resettable counters for the four events
// - keep twelve newest records, drop oldest
// - record taken at active ON transition
// - record holds time, group, remaining, elapsed
// - group switch changes release time while running
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
`include "guard_map.vh"
module close_onto_fault_guard #(
	parameter TICK_CYCLES = `TICK_CYCLES,
	parameter GROUPS      = 8,
	parameter GW          = 3,
	parameter TW          = 21,
	parameter CW          = 16,
	parameter REC_DEPTH   = 12
) (
	// clock and reset
	input  wire          clk_in,
	input  wire          rst_n_in,
	// apb slave
	input  wire          psel_in,
	input  wire          penable_in,
	input  wire          pwrite_in,
	input  wire [7:0]    paddr_in,
	input  wire [31:0]   pwdata_in,
	output reg  [31:0]   prdata_out,
	output wire          pready_out,
	output reg           pslverr_out,
	// binary inputs from pins
	input  wire          arm_input_in,
	input  wire          inhibit_input_in,
	input  wire          protection_start_input_in,
	// active setting group from on-chip logic
	input  wire [GW-1:0] setting_group_select_in,
	// function outputs
	output wire          armed_output_out,
	output wire          trip_output_out,
	output wire [4:0]    condition_out,
	output wire [TW-1:0] remaining_time_value_out,
	// event stream {trip, active, blocked, init}
	output reg  [3:0]    event_on_out,
	output reg  [3:0]    event_off_out,
	output reg  [31:0]   event_time_out,
	// interrupt
	output wire          irq_out
);
	localparam S_IDLE = 2'b01;
	localparam S_RUN  = 2'b10;
	localparam RW     = 32 + GW + 2 * TW;

	function [TW-1:0] sat_sub;
		input [TW-1:0] a;
		input [TW-1:0] b;
		begin
			sat_sub = (a > b) ? a - b : {TW{1'b0}};
		end
	endfunction

	// three-stage pin filter: a change counts once stages 2 and 3 agree
	reg  [2:0]    pin_s1;
	reg  [2:0]    pin_s2;
	reg  [2:0]    pin_s3;
	reg  [2:0]    pin_lvl;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_s1  <= 3'h0;
			pin_s2  <= 3'h0;
			pin_s3  <= 3'h0;
			pin_lvl <= 3'h0;
		end else begin
			pin_s1  <= {protection_start_input_in, inhibit_input_in,
				arm_input_in};
			pin_s2  <= pin_s1;
			pin_s3  <= pin_s2;
			pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 ^ pin_s3));
		end
	end
	wire arm_l   = pin_lvl[0];
	wire inh_l   = pin_lvl[1];
	wire start_l = pin_lvl[2];

	reg  [31:0]   tick_cnt;
	reg  [31:0]   stamp;
	reg  [1:0]    state;
	reg           arm_prev;
	reg  [TW-1:0] elapsed;
	reg  [TW-1:0] rel_time [0:GROUPS-1];
	reg  [31:0]   ctrl;
	reg  [7:0]    evsel;
	reg  [7:0]    irq_stat;
	reg  [7:0]    irq_mask;
	reg  [3:0]    ev_prev;
	reg  [3:0]    rec_sel;
	reg  [CW-1:0] cnt [0:3];

	wire          tick     = (tick_cnt == TICK_CYCLES - 1);
	wire          arm_rise = arm_l & ~arm_prev;
	wire          running  = (state == S_RUN);
	wire [TW-1:0] cur_rel  = rel_time[setting_group_select_in];
	wire [TW-1:0] remain   = running ? sat_sub(cur_rel, elapsed)
		: {TW{1'b0}};
	wire          wr_en    = psel_in & penable_in & pwrite_in;
	wire          forcing  = ctrl[`CTRL_FORCE_EN];
	wire [1:0]    fsel     = ctrl[`CTRL_FORCE_HI:`CTRL_FORCE_LO];

	// time base: millisecond tick and time stamp, software may preset it
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_cnt <= 32'h0000_0000;
			stamp    <= 32'h0000_0000;
		end else begin
			tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 1'b1;
			if (wr_en && paddr_in == `OFS_STAMP)
				stamp <= pwdata_in;
			else if (tick)
				stamp <= stamp + 1'b1;
		end
	end

	// window state machine; elapsed is compared with the live group
	// setting so a group switch takes effect in the next cycle
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state    <= S_IDLE;
			arm_prev <= 1'b0;
			elapsed  <= {TW{1'b0}};
		end else begin
			arm_prev <= arm_l;
			case (state)
			S_IDLE: begin
				if (arm_rise && !inh_l) begin
					state   <= S_RUN;
					elapsed <= {TW{1'b0}};
				end
			end
			S_RUN: begin
				if (arm_rise && !inh_l)
					elapsed <= {TW{1'b0}};
				else if (elapsed >= cur_rel)
					state <= S_IDLE;
				else if (tick)
					elapsed <= elapsed + 1'b1;
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

	// outputs; trip follows the filtered start level with no extra flop
	assign armed_output_out = forcing
		? (fsel == `FORCE_ACTIVE || fsel == `FORCE_TRIP) : running;
	assign trip_output_out = forcing ? (fsel == `FORCE_TRIP)
		: (running & start_l);
	assign remaining_time_value_out = remain;

	reg [4:0] cond;
	always @* begin
		cond = 5'h00;
		if (forcing) begin
			case (fsel)
			`FORCE_BLOCKED: cond[`COND_BLOCKED] = 1'b1;
			`FORCE_ACTIVE:  cond[`COND_ACTIVE]  = 1'b1;
			`FORCE_TRIP:    cond[`COND_TRIP]    = 1'b1;
			default:        cond[`COND_NORMAL]  = 1'b1;
			endcase
		end else if (inh_l)
			cond[`COND_BLOCKED] = 1'b1;
		else if (running && start_l)
			cond[`COND_TRIP] = 1'b1;
		else if (running)
			cond[`COND_ACTIVE] = 1'b1;
		else if (arm_l)
			cond[`COND_INIT] = 1'b1;
		else
			cond[`COND_NORMAL] = 1'b1;
	end
	assign condition_out = cond;

	// events: bit 0 init, 1 blocked, 2 active, 3 trip
	wire [3:0] ev_lvl = cond[4:1];
	wire [3:0] ev_on  = ev_lvl & ~ev_prev;
	wire [3:0] ev_off = ~ev_lvl & ev_prev;
	wire [7:0] irq_clr = (wr_en && paddr_in == `OFS_IRQ_STAT)
		? pwdata_in[7:0] : 8'h00;
	wire [3:0] cnt_clr = (wr_en && paddr_in == `OFS_CNT_CLR)
		? pwdata_in[3:0] : 4'h0;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ev_prev        <= 4'h0;
			event_on_out   <= 4'h0;
			event_off_out  <= 4'h0;
			event_time_out <= 32'h0000_0000;
			irq_stat       <= 8'h00;
		end else begin
			ev_prev       <= ev_lvl;
			event_on_out  <= ev_on & evsel[3:0];
			event_off_out <= ev_off & evsel[7:4];
			if (|{ev_on, ev_off})
				event_time_out <= stamp;
			// a new event wins over a clear in the same cycle
			irq_stat <= (irq_stat & ~irq_clr) | {ev_off, ev_on};
		end
	end
	assign irq_out = |(irq_stat & irq_mask);

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_cnt
			always @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in)
					cnt[g] <= {CW{1'b0}};
				else
					cnt[g] <= (cnt_clr[g] ? {CW{1'b0}} : cnt[g])
						+ {{(CW-1){1'b0}}, ev_on[g]};
			end
		end
	endgenerate

	// operation records
	wire [RW-1:0] rec_data;
	wire [3:0]    rec_count;
	guard_record_buf #(
		.DEPTH (REC_DEPTH),
		.W     (RW),
		.AW    (4)
	) u_rec (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.push_in   (ev_on[2]),
		.data_in   ({stamp, setting_group_select_in, remain,
			elapsed}),
		.sel_in    (rec_sel),
		.data_out  (rec_data),
		.count_out (rec_count)
	);

	// register writes
	integer k;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl     <= `RST_CTRL;
			evsel    <= `RST_EVSEL;
			irq_mask <= `RST_IRQ_MASK;
			rec_sel  <= 4'h0;
			for (k = 0; k < GROUPS; k = k + 1)
				rel_time[k] <= `RST_REL_MS;
		end else if (wr_en) begin
			case (paddr_in)
			`OFS_CTRL:     ctrl     <= {29'h0000_0000, pwdata_in[2:0]};
			`OFS_EVSEL:    evsel    <= pwdata_in[7:0];
			`OFS_IRQ_MASK: irq_mask <= pwdata_in[7:0];
			`OFS_REC_SEL:  rec_sel  <= pwdata_in[3:0];
			default: begin
				for (k = 0; k < GROUPS; k = k + 1)
					if (paddr_in == `OFS_REL_BASE + 4 * k)
						rel_time[k] <= pwdata_in[TW-1:0];
			end
			endcase
		end
	end

	// read data is captured in the setup cycle, so pready can stay high
	reg [31:0] next_rdata;
	reg        next_err;
	integer    m;
	always @* begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		case (paddr_in)
		`OFS_CTRL:      next_rdata = ctrl;
		`OFS_COND:      next_rdata = {27'h000_0000, cond};
		`OFS_REMAIN:    next_rdata = {{(32-TW){1'b0}}, remain};
		`OFS_ELAPSED:   next_rdata = {{(32-TW){1'b0}}, elapsed};
		`OFS_EVSEL:     next_rdata = {24'h00_0000, evsel};
		`OFS_IRQ_STAT:  next_rdata = {24'h00_0000, irq_stat};
		`OFS_IRQ_MASK:  next_rdata = {24'h00_0000, irq_mask};
		`OFS_CNT_CLR:   next_rdata = 32'h0000_0000;
		`OFS_STAMP:     next_rdata = stamp;
		`OFS_REC_SEL:   next_rdata = {28'h000_0000, rec_sel};
		`OFS_REC_TIME:  next_rdata = rec_data[RW-1:RW-32];
		`OFS_REC_INFO:  next_rdata = {5'h00, rec_data[2*TW+GW-1:2*TW],
			3'h0, rec_data[2*TW-1:TW]};
		`OFS_REC_ACT:   next_rdata = {{(32-TW){1'b0}}, rec_data[TW-1:0]};
		`OFS_REC_COUNT: next_rdata = {28'h000_0000, rec_count};
		default: begin
			next_err = 1'b1;
			for (m = 0; m < 4; m = m + 1)
				if (paddr_in == `OFS_CNT_BASE + 4 * m) begin
					next_rdata = {{(32-CW){1'b0}}, cnt[m]};
					next_err   = 1'b0;
				end
			for (m = 0; m < GROUPS; m = m + 1)
				if (paddr_in == `OFS_REL_BASE + 4 * m) begin
					next_rdata = {{(32-TW){1'b0}}, rel_time[m]};
					next_err   = 1'b0;
				end
		end
		endcase
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prdata_out  <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else if (psel_in && !penable_in) begin
			prdata_out  <= pwrite_in ? 32'h0000_0000 : next_rdata;
			pslverr_out <= next_err;
		end else if (!psel_in) begin
			pslverr_out <= 1'b0;
		end
	end
	assign pready_out = 1'b1;
endmodule // close_onto_fault_guard

// File: rtl/guard_map.vh
`ifndef GUARD_MAP_VH
`define GUARD_MAP_VH

// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_COND      8'h04
`define OFS_REMAIN    8'h08
`define OFS_ELAPSED   8'h0c
`define OFS_EVSEL     8'h10
`define OFS_IRQ_STAT  8'h14
`define OFS_IRQ_MASK  8'h18
`define OFS_CNT_CLR   8'h1c
`define OFS_CNT_BASE  8'h20
`define OFS_STAMP     8'h30
`define OFS_REC_SEL   8'h34
`define OFS_REC_TIME  8'h38
`define OFS_REC_INFO  8'h3c
`define OFS_REC_ACT   8'h40
`define OFS_REC_COUNT 8'h44
`define OFS_REL_BASE  8'h80

// field positions
`define CTRL_FORCE_EN    0
`define CTRL_FORCE_LO    1
`define CTRL_FORCE_HI    2
`define REC_INFO_GRP_LO  24

// force selections
`define FORCE_NORMAL  2'h0
`define FORCE_BLOCKED 2'h1
`define FORCE_ACTIVE  2'h2
`define FORCE_TRIP    2'h3

// condition one-hot bit positions
`define COND_NORMAL  0
`define COND_INIT    1
`define COND_BLOCKED 2
`define COND_ACTIVE  3
`define COND_TRIP    4

// reset values
`define RST_CTRL     32'h0000_0000
`define RST_EVSEL    8'hff
`define RST_IRQ_MASK 8'h00
`define RST_REL_MS   21'h00_03e8

// timing
`define TICK_MS      1
`define CLK_MHZ      100
`define TICK_CYCLES  (`TICK_MS * `CLK_MHZ * 1000)

`endif

// File: rtl/guard_record_buf.v
`timescale 1ns/10ps
module guard_record_buf #(
	parameter DEPTH = 12,
	parameter W     = 77,
	parameter AW    = 4
) (
	// clock and reset
	input  wire          clk_in,
	input  wire          rst_n_in,
	// new record
	input  wire          push_in,
	input  wire [W-1:0]  data_in,
	// readback, index 0 is the newest
	input  wire [AW-1:0] sel_in,
	output wire [W-1:0]  data_out,
	output reg  [AW-1:0] count_out
);
	reg [W-1:0]  mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW:0]   raw_idx;
	reg [AW-1:0] rd_idx;
	integer      i;

	// oldest entry is simply overwritten once the ring is full
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr    <= {AW{1'b0}};
			count_out <= {AW{1'b0}};
			for (i = 0; i < DEPTH; i = i + 1)
				mem[i] <= {W{1'b0}};
		end else if (push_in) begin
			mem[wr_ptr] <= data_in;
			wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (count_out != DEPTH)
				count_out <= count_out + 1'b1;
		end
	end

	always @* begin
		raw_idx = {1'b0, wr_ptr} + DEPTH[AW:0] - 1'b1 - {1'b0, sel_in};
		if (raw_idx >= DEPTH[AW:0])
			raw_idx = raw_idx - DEPTH[AW:0];
		rd_idx = raw_idx[AW-1:0];
	end

	assign data_out = (sel_in < count_out) ? mem[rd_idx] : {W{1'b0}};
endmodule // guard_record_buf

// File: tb/close_onto_fault_guard_tb.sv
`timescale 1ns/10ps
`include "guard_map.vh"
module close_onto_fault_guard_tb;
	logic          clk_in, rst_n_in, psel_in, penable_in, pwrite_in, err;
	logic [7:0]    paddr_in;
	logic [31:0]   pwdata_in, q;
	logic [2:0]    setting_group_select_in;
	wire  [31:0]   prdata_out, event_time_out;
	wire           pready_out, pslverr_out, irq_out;
	wire           armed_output_out, trip_output_out;
	wire           arm_input_in, inhibit_input_in, protection_start_input_in;
	wire  [4:0]    condition_out;
	wire  [20:0]   remaining_time_value_out;
	wire  [3:0]    event_on_out, event_off_out;
	integer        err_total = 0;
	integer        checks_done = 0;
	integer        cyc = 0;
	integer        i, n;
	integer        on_pulses = 0, off_pulses = 0, on_base, off_base;
	logic [31:0]   ftab [5] = '{32'h7, 32'h5, 32'h3, 32'h1, 32'h6};
	logic [4:0]    ctab [5] = '{5'h10, 5'h08, 5'h04, 5'h01, 5'h01};

	// a short tick keeps millisecond windows to tens of cycles
	close_onto_fault_guard #(.TICK_CYCLES(10)) close_onto_fault_guard_inst (
		.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
		.pwdata_in, .prdata_out, .pready_out, .pslverr_out, .arm_input_in,
		.inhibit_input_in, .protection_start_input_in,
		.setting_group_select_in, .armed_output_out, .trip_output_out,
		.condition_out, .remaining_time_value_out, .event_on_out,
		.event_off_out, .event_time_out, .irq_out);
	field_side field_side_inst (.clk_in, .arm_out(arm_input_in),
		.inhibit_out(inhibit_input_in), .start_out(protection_start_input_in));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (|event_on_out)
			on_pulses <= on_pulses + 1;
		if (|event_off_out)
			off_pulses <= off_pulses + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			tally_and_finish;
		end
	end

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		@(posedge clk_in);
		while (pready_out !== 1'b1) @(posedge clk_in);
		q = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk_word(q, exp);
	endtask
	task wt(input integer c);
		repeat (c) @(posedge clk_in);
	endtask

	initial begin
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
		setting_group_select_in = 3'h0;
		rst_n_in = 1'b0;
		wt(3);
		rst_n_in <= 1'b1;
		rd_chk(`OFS_CTRL, `RST_CTRL);
		rd_chk(`OFS_COND, 32'h0000_0001);
		rd_chk(`OFS_EVSEL, 32'h0000_00ff);
		rd_chk(`OFS_IRQ_MASK, 32'h0000_0000);
		rd_chk(`OFS_REL_BASE, 32'h0000_03e8);
		apb(1'b0, 8'h48, 32'h0);
		chk_bit(err, 1'b1);
		apb(1'b1, `OFS_REL_BASE, 32'h0000_0002);
		apb(1'b1, `OFS_REL_BASE + 8'h04, 32'h0000_0005);
		apb(1'b1, `OFS_REL_BASE + 8'h08, 32'h0000_0000);
		apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0004);
		field_side_inst.drive(1'b1, 1'b0, 1'b0);
		wt(8);
		chk_bit(armed_output_out, 1'b1);
		chk_bit(condition_out[`COND_ACTIVE], 1'b1);
		chk_bit(irq_out, 1'b1);
		n = 0;
		while (armed_output_out) begin
			wt(1);
			n = n + 1;
		end
		chk_bit(n >= 10 && n <= 22, 1'b1);
		wt(30);
		chk_bit(armed_output_out, 1'b0);
		chk_bit(condition_out[`COND_INIT], 1'b1);
		rd_chk(`OFS_CNT_BASE + 8'h08, 32'h0000_0001);
		apb(1'b1, `OFS_CNT_CLR, 32'h0000_0004);
		rd_chk(`OFS_CNT_BASE + 8'h08, 32'h0000_0000);
		rd_chk(`OFS_REC_COUNT, 32'h0000_0001);
		rd_chk(`OFS_REC_INFO, 32'h0000_0002);
		apb(1'b0, `OFS_IRQ_STAT, 32'h0);
		chk_bit(q[2], 1'b1);
		apb(1'b1, `OFS_IRQ_STAT, 32'h0000_00ff);
		wt(1);
		chk_bit(irq_out, 1'b0);
		chk_bit(event_time_out != 32'h0, 1'b1);
		field_side_inst.drive(1'b0, 1'b1, 1'b0);
		wt(8);
		field_side_inst.drive(1'b1, 1'b1, 1'b0);
		wt(8);
		chk_bit(armed_output_out, 1'b0);
		chk_bit(condition_out[`COND_BLOCKED], 1'b1);
		field_side_inst.drive(1'b0, 1'b0, 1'b0);
		apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0000);
		field_side_inst.drive(1'b1, 1'b0, 1'b0);
		wt(7);
		field_side_inst.drive(1'b1, 1'b0, 1'b1);
		wt(5);
		chk_bit(trip_output_out, 1'b1);
		chk_bit(condition_out[`COND_TRIP], 1'b1);
		chk_bit(irq_out, 1'b0);
		field_side_inst.drive(1'b0, 1'b0, 1'b0);
		wt(30);
		// the longer group keeps the first window open across the re-arm
		setting_group_select_in <= 3'h1;
		field_side_inst.drive(1'b1, 1'b0, 1'b0);
		wt(11);
		field_side_inst.drive(1'b0, 1'b0, 1'b0);
		wt(5);
		field_side_inst.drive(1'b1, 1'b0, 1'b0);
		wt(42);
		chk_bit(armed_output_out, 1'b1);
		setting_group_select_in <= 3'h0;
		field_side_inst.drive(1'b0, 1'b0, 1'b0);
		wt(30);
		field_side_inst.drive(1'b1, 1'b0, 1'b0);
		wt(8);
		setting_group_select_in <= 3'h1;
		wt(27);
		chk_bit(armed_output_out, 1'b1);
		chk_bit(remaining_time_value_out != 21'h00_0000 &&
			remaining_time_value_out <= 21'h00_0005, 1'b1);
		setting_group_select_in <= 3'h0;
		field_side_inst.drive(1'b0, 1'b0, 1'b0);
		wt(30);
		for (i = 0; i < 5; i = i + 1) begin
			apb(1'b1, `OFS_CTRL, ftab[i]);
			wt(2);
			chk_word({27'h0, condition_out}, {27'h0, ctab[i]});
			chk_bit(trip_output_out, i == 0);
		end
		apb(1'b1, `OFS_CTRL, 32'h0000_0000);
		// a zero release gives a one-cycle window, so records come fast
		setting_group_select_in <= 3'h2;
		for (i = 0; i < 13; i = i + 1) begin
			field_side_inst.drive(1'b1, 1'b0, 1'b0);
			wt(7);
			field_side_inst.drive(1'b0, 1'b0, 1'b0);
			wt(7);
		end
		rd_chk(`OFS_REC_COUNT, 32'h0000_000c);
		apb(1'b1, `OFS_REC_SEL, 32'h0000_000b);
		rd_chk(`OFS_REC_INFO, 32'h0200_0000);
		// with off events unselected only the three on pulses may show
		apb(1'b1, `OFS_EVSEL, 32'h0000_000f);
		apb(1'b1, `OFS_STAMP, 32'h0001_0000);
		on_base = on_pulses;
		off_base = off_pulses;
		field_side_inst.drive(1'b1, 1'b0, 1'b0);
		wt(7);
		field_side_inst.drive(1'b0, 1'b0, 1'b0);
		wt(7);
		chk_word(on_pulses - on_base, 32'h0000_0003);
		chk_word(off_pulses - off_base, 32'h0000_0000);
		chk_word(event_time_out & 32'hffff_ff00, 32'h0001_0000);
		tally_and_finish;
	end
endmodule // close_onto_fault_guard_tb

bind close_onto_fault_guard guard_chk #(.TW(TW)) chk_inst (.clk_in,
	.rst_n_in, .psel_in, .penable_in, .paddr_in, .prdata_out, .pready_out,
	.pslverr_out, .armed_output_out, .trip_output_out, .condition_out,
	.remaining_time_value_out, .event_on_out, .event_off_out);

// File: tb/field_side.sv
`timescale 1ns/10ps
module field_side (
	// clock
	input  wire  clk_in,
	// pins toward the guard
	output logic arm_out,
	output logic inhibit_out,
	output logic start_out
);
	initial begin
		arm_out = 1'b0;
		inhibit_out = 1'b0;
		start_out = 1'b0;
	end
	// a breaker close and a digital input both arrive as a plain level
	task automatic drive(input logic a, input logic i, input logic s);
		@(posedge clk_in);
		arm_out <= a;
		inhibit_out <= i;
		start_out <= s;
	endtask
endmodule // field_side

// File: tb/guard_chk.sv
`timescale 1ns/10ps
module guard_chk #(
	parameter TW = 21
) (
	// clock and reset
	input wire          clk_in,
	input wire          rst_n_in,
	// apb
	input wire          psel_in,
	input wire          penable_in,
	input wire [7:0]    paddr_in,
	input wire [31:0]   prdata_out,
	input wire          pready_out,
	input wire          pslverr_out,
	// function
	input wire          armed_output_out,
	input wire          trip_output_out,
	input wire [4:0]    condition_out,
	input wire [TW-1:0] remaining_time_value_out,
	input wire [3:0]    event_on_out,
	input wire [3:0]    event_off_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	sequence s_access;
		psel_in && penable_in;
	endsequence
	a_no_wait: assert property (pready_out)
		else $error("pready low");
	a_read_hold: assert property (s_setup ##1 s_access |=>
		$stable(prdata_out) && $stable(pslverr_out))
		else $error("read answer moved in access");
	a_err_unmapped: assert property (s_setup and
		(paddr_in >= 8'h48 && paddr_in <= 8'h7c) |=> pslverr_out)
		else $error("no error on unmapped");
	a_err_mapped: assert property (s_setup and
		(paddr_in < 8'h48) |=> !pslverr_out)
		else $error("error on mapped");
	a_err_idle: assert property (!$past(psel_in) |-> !pslverr_out)
		else $error("error without select");
	a_cond_onehot: assert property ($onehot(condition_out))
		else $error("condition not one-hot");
	a_trip_armed: assert property (trip_output_out |-> armed_output_out)
		else $error("trip outside window");
	a_idle_zero: assert property (!armed_output_out |->
		remaining_time_value_out == 0)
		else $error("time left while idle");
	a_evt_apart: assert property ((event_on_out & event_off_out) == 4'h0)
		else $error("on and off together");
	a_evt_pulse: assert property (|event_on_out |=>
		(event_on_out & $past(event_on_out)) == 4'h0)
		else $error("event longer than a cycle");
endmodule // guard_chk
